//--- src/board_ctl_pkg.sv
// Shared constants and types for the board watchdog and GPIO control block.
package board_ctl_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [11:0] out_value_offset  = 12'h000;
    localparam logic [11:0] out_enable_offset = 12'h004;
    localparam logic [11:0] wdt_status_offset = 12'h008;
    // Field positions: bit n sets line n, bit n plus this clears it.
    localparam int          clear_field_shift = 16;
    localparam int          line_count        = 16;
    // Line numbers of the board functions.
    localparam int          port3_tx_line     = 5;
    localparam int          port4_tx_line     = 6;
    localparam int          wdt_enable_bit    = 8;
    localparam int          first_ind_bit     = 9;
    localparam int          wdt_strobe_bit    = 10;
    localparam int          second_ind_bit    = 11;
    // Reset values: lines are inputs and read low, indicators dark.
    localparam logic [15:0] out_value_reset   = 16'h0a60;
    localparam logic [15:0] out_enable_reset  = 16'h0000;
    // Watchdog timing.
    localparam int          wdt_timeout_ms    = 1600;
    localparam int          clk_khz           = 40000;
    localparam int          wdt_timeout_cycles = wdt_timeout_ms * clk_khz;
    localparam int          reset_pulse_cycles = 16;
    // APB request carried as one group.
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } apb_req_type;
    typedef enum { wdt_idle, wdt_counting, wdt_fired } wdt_state_type;
endpackage

//--- src/gpio_line_bank.sv
// Set/clear register pair that holds one bit per GPIO line.
`timescale 1ns/1ps
module gpio_line_bank
    import board_ctl_pkg::*;
#(
    parameter int          width      = 16,
    parameter logic [15:0] reset_bits = 16'h0000
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              write_strobe,
    input  wire logic [31:0]       wdata,
    output logic      [width-1:0]  bits
);
    logic [width-1:0] next_bits;

    // A set bit wins only when its clear partner is low; both or neither leave the line alone.
    always_comb begin
        next_bits = bits;
        for (int n = 0; n < width; n++) begin
            if (write_strobe && wdata[n] && !wdata[n + clear_field_shift]) begin
                next_bits[n] = 1'b1; // RL8 RL9
            end else if (write_strobe && !wdata[n] && wdata[n + clear_field_shift]) begin
                next_bits[n] = 1'b0; // RL8 RL9
            end
        end
    end

    // Register the line bits.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bits <= reset_bits[width-1:0];
        end else begin
            bits <= next_bits;
        end
    end
endmodule

//--- src/board_watchdog.sv
// Fixed-period supervisor watchdog retriggered by strobe transitions.
`timescale 1ns/1ps
module board_watchdog
    import board_ctl_pkg::*;
#(
    parameter int timeout_cycles = wdt_timeout_cycles
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic wdt_enable_line,
    input  wire logic wdt_strobe_line,
    output logic      expired,
    output logic      reset_request
);
    logic [31:0]   count;
    logic [31:0]   next_count;
    logic [4:0]    pulse;
    logic [4:0]    next_pulse;
    logic          strobe_prev;
    wdt_state_type state;
    wdt_state_type next_state;

    // Count while enabled; any strobe edge starts over, disabling returns to idle except during a reset pulse, which runs to its end.
    always_comb begin
        next_state = state;
        next_count = count;
        next_pulse = pulse;
        case (state)
            wdt_idle: begin
                next_count = 32'h0000_0000;
                if (wdt_enable_line) begin
                    next_state = wdt_counting; // RL3
                end
            end
            wdt_counting: begin
                if (!wdt_enable_line) begin
                    next_state = wdt_idle; // RL3
                end else if (wdt_strobe_line != strobe_prev) begin
                    next_count = 32'h0000_0000; // RL4 RL5
                end else if (count == 32'(timeout_cycles - 1)) begin
                    next_state = wdt_fired; // RL1
                    next_pulse = 5'(reset_pulse_cycles);
                end else begin
                    next_count = count + 32'h0000_0001; // RL1
                end
            end
            wdt_fired: begin
                next_count = 32'h0000_0000;
                if (pulse != 5'h00) begin
                    next_pulse = pulse - 5'h01; // RL5
                end else begin
                    next_state = wdt_idle;
                end
            end
            default: next_state = wdt_idle;
        endcase
    end

    // Register state; the board reset asserts while the pulse runs.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state         <= wdt_idle;
            count         <= 32'h0000_0000;
            pulse         <= 5'h00;
            strobe_prev   <= 1'b0;
            expired       <= 1'b0;
            reset_request <= 1'b0;
        end else begin
            state         <= next_state;
            count         <= next_count;
            pulse         <= next_pulse;
            strobe_prev   <= wdt_strobe_line;
            expired       <= (next_state == wdt_fired) ? 1'b1 : expired;
            reset_request <= (next_state == wdt_fired); // RL5
        end
    end
endmodule

//--- src/board_ctl_top.sv
// Top of the board control block: APB registers, GPIO lines, watchdog and board outputs.
//
// Summary of operation
// RL1: Watchdog expires after fixed 1.6 s without strobe.
// RL2: Firmware leaves watchdog disabled after self test.
// RL3: Enable line one runs watchdog, zero stops it.
// RL4: Strobe line toggles keep the watchdog alive.
// RL5: Strobe edge restarts count; expiry asserts board reset.
// RL6: Indicator lights on drive zero, dark on one.
// RL7: Port 3 and 4 transmitters enabled on one.
// RL8: Output-enable word: set n, clear n+16 makes output.
// RL9: Output-value word: set/clear pair drives line high/low.
`timescale 1ns/1ps
module board_ctl_top
    import board_ctl_pkg::*;
#(
    parameter int timeout_cycles = wdt_timeout_cycles
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             first_user_indicator_n,
    output logic             second_user_indicator_n,
    output logic             port3_tx_enable,
    output logic             port4_tx_enable,
    output logic             board_reset_n
);
    apb_req_type      req;
    logic [15:0]      line_value;
    logic [15:0]      line_enable;
    logic [15:0]      line_level;
    logic             access;
    logic             complete;
    logic             write_value;
    logic             write_enable;
    logic             mapped;
    logic [31:0]      next_prdata;
    logic             next_pslverr;
    logic             wdt_expired;
    logic             wdt_reset_request;

    // Group the bus request so the decode reads as one record.
    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

    // The access edge launches pready; a write lands only at the edge where the master sees pready high.
    assign access       = req.sel && req.enable && !pready;
    assign complete     = req.sel && req.enable && pready;
    assign mapped       = (req.addr == out_value_offset) || (req.addr == out_enable_offset)
                          || (req.addr == wdt_status_offset);
    assign write_value  = complete && req.write && (req.addr == out_value_offset);
    assign write_enable = complete && req.write && (req.addr == out_enable_offset);

    // Line level: a line not set as output floats to the low level on this board.
    assign line_level = line_value & line_enable; // RL8

    // Output-value register pair.
    gpio_line_bank #(
        .width      (line_count),
        .reset_bits (out_value_reset)
    ) value_bank (
        .clk          (clk),
        .rst_n        (rst_n),
        .write_strobe (write_value),
        .wdata        (req.wdata),
        .bits         (line_value)
    );

    // Output-enable register pair.
    gpio_line_bank #(
        .width      (line_count),
        .reset_bits (out_enable_reset)
    ) enable_bank (
        .clk          (clk),
        .rst_n        (rst_n),
        .write_strobe (write_enable),
        .wdata        (req.wdata),
        .bits         (line_enable)
    );

    // Watchdog on its two lines; it starts disabled since enable resets to input.
    board_watchdog #(
        .timeout_cycles (timeout_cycles)
    ) watchdog (
        .clk             (clk),
        .rst_n           (rst_n),
        .wdt_enable_line (line_level[wdt_enable_bit]), // RL2 RL3
        .wdt_strobe_line (line_level[wdt_strobe_bit]), // RL4
        .expired         (wdt_expired),
        .reset_request   (wdt_reset_request)
    );

    // Read mux: value and enable words return the set bits with their clear partners inverted.
    always_comb begin
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        if (access) begin
            next_pslverr = !mapped;
            next_prdata  = 32'h0000_0000;
            if (!req.write) begin
                case (req.addr)
                    out_value_offset:  next_prdata = {~line_value, line_value};
                    out_enable_offset: next_prdata = {~line_enable, line_enable};
                    wdt_status_offset: next_prdata = {30'h0000_0000, wdt_expired, line_level[wdt_enable_bit]};
                    default:           next_prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // Bus answer registers; pready is a one-cycle pulse per access.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= access;
            pslverr <= next_pslverr;
        end
    end

    // Board pins are registered so they never glitch on decode.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_user_indicator_n  <= 1'b1;
            second_user_indicator_n <= 1'b1;
            port3_tx_enable         <= 1'b0;
            port4_tx_enable         <= 1'b0;
            board_reset_n           <= 1'b1;
        end else begin
            first_user_indicator_n  <= line_level[first_ind_bit] | ~line_enable[first_ind_bit]; // RL6
            second_user_indicator_n <= line_level[second_ind_bit] | ~line_enable[second_ind_bit]; // RL6
            port3_tx_enable         <= line_level[port3_tx_line]; // RL7
            port4_tx_enable         <= line_level[port4_tx_line]; // RL7
            board_reset_n           <= ~wdt_reset_request; // RL5
        end
    end
endmodule

//--- dv/board_ctl_assertions.sv
// Bus handshake and watchdog pulse checks on the board control block ports.
`timescale 1ns/1ps
module board_ctl_assertions #(
    parameter int timeout_cycles = 50
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        board_reset_n
);
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic acc;
    int   quiet;
    int   next_quiet;
    // Any write that may move the enable or strobe line restarts the count, so a legal expiry never trips it.
    assign acc = psel && penable && !pready;
    always_comb begin
        next_quiet = (quiet < timeout_cycles) ? quiet + 1 : quiet;
        if (acc && pwrite && paddr[11:3] == 9'h0 && |{pwdata[26], pwdata[24], pwdata[10], pwdata[8]}) begin
            next_quiet = 0;
        end
    end
    // Quiet counter register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet <= 0;
        end else begin
            quiet <= next_quiet;
        end
    end
    // Handshake, refusal and reset pulse relations.
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
    a_ready_after_access: assert property (acc |=> pready) else $error("no pready");
    a_setup_no_ready: assert property (psel && !penable |=> !pready) else $error("early pready");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
    a_unmapped_err: assert property (acc && !(paddr inside {12'h000, 12'h004, 12'h008}) |=> pslverr)
        else $error("no pslverr");
    a_mapped_ok: assert property (acc && paddr inside {12'h000, 12'h004, 12'h008} |=> !pslverr)
        else $error("bad pslverr");
    a_pulse_length: assert property ($fell(board_reset_n) |=>
        !board_reset_n [*8] ##1 !board_reset_n [*8] ##1 board_reset_n) else $error("bad reset pulse");
    a_expiry_quiet: assert property ($fell(board_reset_n) |-> quiet >= timeout_cycles - 4)
        else $error("early expiry");
    c_expiry: cover property ($fell(board_reset_n));
    c_write: cover property (acc && pwrite);
    c_refused: cover property (acc ##1 pslverr);
endmodule
bind board_ctl_top board_ctl_assertions #(.timeout_cycles(timeout_cycles)) u_board_ctl_assertions (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .board_reset_n(board_reset_n));

//--- dv/host_sw_model.sv
// Software-side APB master model that drives the board control registers.
`timescale 1ns/1ps
module host_sw_model
    import board_ctl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output apb_req_type      req
);
    int timeouts = 0;
    // Bus idle at power-up; the watchdog stays off until a scenario enables it.
    initial req = '0;
    // One transfer after a free edge; released address and data are inverted so stale values never match.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        int n;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.enable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        timeouts += (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        req <= '{1'b0, 1'b0, w, ~a, ~d};
    endtask
endmodule

//--- dv/board_watchdog_gpio_control_bench.sv
// Self-checking bench for the board watchdog and GPIO control block.
`timescale 1ns/1ps
module board_watchdog_gpio_control_bench;
    import board_ctl_pkg::*;
    localparam int tmo = 50;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    apb_req_type req;
    logic [31:0] prdata;
    logic        pready, pslverr, ind1_n, ind2_n, tx3, tx4, brst_n;
    int          errors = 0;
    int          n_tests = 0;
    // A short timeout keeps the run brief.
    always #12.5 clk = ~clk;
    host_sw_model u_host_sw_model (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .req(req));
    board_ctl_top #(.timeout_cycles(tmo)) u_board_ctl_top (.clk(clk), .rst_n(rst_n), .psel(req.sel),
        .penable(req.enable), .pwrite(req.write), .paddr(req.addr), .pwdata(req.wdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .first_user_indicator_n(ind1_n), .second_user_indicator_n(ind2_n),
        .port3_tx_enable(tx3), .port4_tx_enable(tx4), .board_reset_n(brst_n));
    // Verdict and end of run.
    task automatic test_done();
        errors += u_host_sw_model.timeouts;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Word compare.
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus cycles; a hung handshake ends the run at once.
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic ee);
        logic [31:0] q;
        logic        e;
        u_host_sw_model.xfer(1'b0, a, 32'h0, q, e);
        if (u_host_sw_model.timeouts != 0) test_done();
        cmp(q, ed);
        cmp({31'h0, e}, {31'h0, ee});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        u_host_sw_model.xfer(1'b1, a, d, q, e);
        if (u_host_sw_model.timeouts != 0) test_done();
    endtask
    // Pins as ind1, ind2, tx3, tx4, board reset, after the two-edge output lag.
    task automatic pins(input logic [4:0] e);
        repeat (2) @(posedge clk);
        #1;
        cmp({27'h0, ind1_n, ind2_n, tx3, tx4, brst_n}, {27'h0, e});
    endtask
    task automatic t_reset();
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        pins(5'b11001);
        rd(out_value_offset, {~out_value_reset, out_value_reset}, 1'b0);
        rd(out_enable_offset, 32'hffff0000, 1'b0);
        rd(wdt_status_offset, 32'h0, 1'b0);
        rd(12'h00c, 32'h0, 1'b1);
    endtask
    task automatic t_lines();
        wr(out_enable_offset, 32'h00000a60);
        pins(5'b11111);
        wr(out_value_offset, 32'h0a000000);
        pins(5'b00111);
        wr(out_value_offset, 32'h00600a00);
        pins(5'b11001);
        wr(out_value_offset, 32'h00200020);
        wr(out_enable_offset, 32'h00400000);
        rd(out_enable_offset, 32'hf5df0a20, 1'b0);
        rd(out_value_offset, 32'hf5ff0a00, 1'b0);
    endtask
    task automatic t_wdog();
        int n;
        wr(out_enable_offset, 32'h00000500);
        repeat (2 * tmo) @(posedge clk);
        pins(5'b11001);
        wr(out_value_offset, 32'h00000100);
        for (n = 0; n < 6; n++) begin
            repeat (tmo / 2) @(posedge clk);
            wr(out_value_offset, n[0] ? 32'h04000000 : 32'h00000400);
        end
        pins(5'b11001);
        for (n = 0; brst_n !== 1'b0 && n < 4 * tmo; n++) begin
            @(posedge clk);
            #1;
        end
        cmp({31'h0, n >= tmo - 6 && n <= tmo + 4}, 32'h1);
        for (n = 0; brst_n === 1'b0 && n < 40; n++) begin
            @(posedge clk);
            #1;
        end
        cmp(n, 32'd17);
        rd(wdt_status_offset, 32'h3, 1'b0);
        wr(out_value_offset, 32'h01000000);
        repeat (3 * tmo) @(posedge clk);
        pins(5'b11001);
        rd(wdt_status_offset, 32'h2, 1'b0);
    endtask
    // The second reset also clears the sticky expiry flag.
    initial begin
        t_reset();
        t_lines();
        t_wdog();
        t_reset();
        test_done();
    end
endmodule
